// file: design/oss_pkg.sv
// ----------------------------------------------------------------
// Oscillator select and status constants
// ----------------------------------------------------------------
package oss_pkg;

	// Clock of the register side, in MHz
	localparam int unsigned OSS_CLK_MHZ = 250;

	// Register indices; byte address is four times the index
	localparam logic [7:0] OSS_IDX_CTRL = 8'h1c;
	localparam logic [7:0] OSS_IDX_STAT = 8'h1d;
	localparam logic [7:0] OSS_IDX_KEY = 8'h1f;
	localparam logic [7:0] OSS_IDX_OUT = 8'h3f;

	// Key values
	localparam logic [7:0] OSS_KEY_OSC = 8'ha1;
	localparam logic [7:0] OSS_KEY_CLEARED = 8'h00;

	// Control field positions
	localparam int unsigned OSS_C_SRC = 7;
	localparam int unsigned OSS_C_AUTOCAL_MODE_FIELD_HI = 6;
	localparam int unsigned OSS_C_AUTOCAL_MODE_FIELD_LO = 5;
	localparam int unsigned OSS_C_AOS = 4;
	localparam int unsigned OSS_C_FOS = 3;
	localparam int unsigned OSS_C_RSVD = 2;
	localparam int unsigned OSS_C_OSC_FAIL_IRQ_ENABLE = 1;
	localparam int unsigned OSS_C_AUTOCAL_FAIL_IRQ_ENABLE = 0;

	// Status field positions
	localparam int unsigned OSS_S_TRIM_HI = 7;
	localparam int unsigned OSS_S_TRIM_LO = 6;
	localparam int unsigned OSS_S_LOCK = 5;
	localparam int unsigned OSS_S_MODE = 4;
	localparam int unsigned OSS_S_OF = 1;
	localparam int unsigned OSS_S_ACF = 0;

	// Second output register field position
	localparam int unsigned OSS_O_LEVEL = 0;

	// Values after reset
	localparam logic [7:0] OSS_CTRL_RST = 8'h00;
	localparam logic [1:0] OSS_TRIM_RST = 2'h0;
	localparam logic OSS_LOCK_RST = 1'b1;
	localparam logic OSS_MODE_RST = 1'b0;
	localparam logic OSS_OF_RST = 1'b1;
	localparam logic OSS_ACF_RST = 1'b0;
	localparam logic OSS_LEVEL_RST = 1'b0;

	// Crystal slow-down per trim step, in ppm
	localparam int unsigned OSS_TRIM_PPM_STEP = 122;

	// Synchroniser depth for pin inputs
	localparam int unsigned OSS_SYNC_STAGES = 3;

endpackage : oss_pkg

// file: design/oss_sync.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Three-flop pin synchroniser with agreement filter
// ----------------------------------------------------------------
module oss_sync #(
	parameter int unsigned WIDTH = 5
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	import oss_pkg::*;

	if (WIDTH < 1) begin : g_chk
		$error("oss_sync needs WIDTH of at least 1");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic [OSS_SYNC_STAGES-1:0] sh_r;
		logic [OSS_SYNC_STAGES-1:0] sh_nxt;
		logic out_r;
		logic out_nxt;

		// Stage one feeds only stage two; the filter reads two and three
		always_comb begin
			sh_nxt = {sh_r[OSS_SYNC_STAGES-2:0], async_i[i]};
			out_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : out_r;
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				sh_r <= '0;
				out_r <= 1'b0;
			end else begin
				sh_r <= sh_nxt;
				out_r <= out_nxt;
			end
		end

		assign sync_o[i] = out_r;
	end

endmodule : oss_sync

// file: design/oss_ctrl.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
module oss_ctrl #(
	parameter int unsigned ADDR_W = 10
) (
	input wire logic MCLK_I,
	input wire logic RESET_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic XT_RUNNING_I,
	input wire logic ON_BATTERY_I,
	input wire logic XT_SLOW_I,
	input wire logic RC_RANGE_FAIL_I,
	input wire logic XT_NO_START_I,
	output logic ACTIVE_SOURCE_RC_O,
	output logic [1:0] CRYSTAL_SLOW_TRIM_O,
	output logic AUTOCAL_START_O,
	output logic [1:0] AUTOCAL_MODE_O,
	output logic SECOND_OUTPUT_PIN_O,
	output logic IRQ_O
);
	import oss_pkg::*;

	if (ADDR_W < 10) begin : g_chk
		$error("oss_ctrl needs ADDR_W of at least 10");
	end

	// ----------------------------------------------------------------
	// Pin inputs
	// ----------------------------------------------------------------
	logic [4:0] pins_s;
	logic xt_run_s;
	logic batt_s;
	logic xt_slow_s;
	logic rc_fail_s;
	logic xt_nostart_s;

	// All five come from the analog side with no relation to MCLK
	oss_sync #(
		.WIDTH(5)
	) u_sync (
		.clk_i(MCLK_I),
		.rst_i(RESET_I),
		.async_i({XT_RUNNING_I, ON_BATTERY_I, XT_SLOW_I, RC_RANGE_FAIL_I, XT_NO_START_I}),
		.sync_o(pins_s)
	);

	assign {xt_run_s, batt_s, xt_slow_s, rc_fail_s, xt_nostart_s} = pins_s;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic access;
	logic aligned;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_key;
	logic hit_out;
	logic mapped;
	logic wr_commit;
	logic high_zero;

	// Address bits above the map must be zero; a ten-bit bus has none,
	// so no reversed part-select is ever built
	if (ADDR_W > 10) begin : g_hi
		assign high_zero = (PADDR_I[ADDR_W-1:10] == '0);
	end else begin : g_nohi
		assign high_zero = 1'b1;
	end

	// Word-aligned index match; byte address is index times four
	assign access = PSEL_I & PENABLE_I;
	assign aligned = (PADDR_I[1:0] == 2'h0) && high_zero;
	assign hit_ctrl = aligned && (PADDR_I[9:2] == OSS_IDX_CTRL);
	assign hit_stat = aligned && (PADDR_I[9:2] == OSS_IDX_STAT);
	assign hit_key = aligned && (PADDR_I[9:2] == OSS_IDX_KEY);
	assign hit_out = aligned && (PADDR_I[9:2] == OSS_IDX_OUT);
	assign mapped = hit_ctrl | hit_stat | hit_key | hit_out;
	// Writes land only at the edge where PREADY is seen high
	assign wr_commit = access & PREADY_O & PWRITE_I & mapped;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [7:0] key_r;
	logic [7:0] key_nxt;
	logic [1:0] trim_r;
	logic [1:0] trim_nxt;
	logic lock_r;
	logic lock_nxt;
	logic mode_r;
	logic mode_nxt;
	logic of_r;
	logic of_nxt;
	logic acf_r;
	logic acf_nxt;
	logic level_r;
	logic level_nxt;
	logic autocal_mode_field_go_r;
	logic autocal_mode_field_go_nxt;
	logic irq_r;
	logic irq_nxt;
	logic key_ok;
	logic rc_want;

	assign key_ok = (key_r == OSS_KEY_OSC);

	// Control register and calibration start
	always_comb begin
		ctrl_nxt = ctrl_r;
		autocal_mode_field_go_nxt = 1'b0;
		if (wr_commit && hit_ctrl && key_ok) begin
			ctrl_nxt = PWDATA_I[7:0];
			ctrl_nxt[OSS_C_RSVD] = 1'b0;
			autocal_mode_field_go_nxt = (PWDATA_I[OSS_C_AUTOCAL_MODE_FIELD_HI:OSS_C_AUTOCAL_MODE_FIELD_LO] != 2'h0);
		end
	end

	// Key is single-use: any write to a mapped register wipes it unless it is the key write
	always_comb begin
		key_nxt = key_r;
		if (wr_commit) begin
			key_nxt = hit_key ? PWDATA_I[7:0] : OSS_KEY_CLEARED;
		end
	end

	// Status writable fields; no key needed here
	always_comb begin
		trim_nxt = trim_r;
		lock_nxt = lock_r;
		if (wr_commit && hit_stat) begin
			trim_nxt = PWDATA_I[OSS_S_TRIM_HI:OSS_S_TRIM_LO];
			lock_nxt = PWDATA_I[OSS_S_LOCK];
		end
	end

	// Sticky flags: a detection in the clearing cycle wins
	always_comb begin
		of_nxt = of_r;
		acf_nxt = acf_r;
		if (wr_commit && hit_stat && !PWDATA_I[OSS_S_OF]) begin
			of_nxt = 1'b0;
		end
		if (wr_commit && hit_stat && !PWDATA_I[OSS_S_ACF]) begin
			acf_nxt = 1'b0;
		end
		if (xt_slow_s) begin
			of_nxt = 1'b1;
		end
		if (rc_fail_s || xt_nostart_s) begin
			acf_nxt = 1'b1;
		end
	end

	// Second output level; a set attempt under lock is dropped
	always_comb begin
		level_nxt = level_r;
		if (wr_commit && hit_out) begin
			if (!(PWDATA_I[OSS_O_LEVEL] && lock_r)) begin
				level_nxt = PWDATA_I[OSS_O_LEVEL];
			end
		end
	end

	// Source selection; RC reasons are ORed together
	assign rc_want = ctrl_r[OSS_C_SRC]
		| (ctrl_r[OSS_C_AOS] & batt_s)
		| (ctrl_r[OSS_C_FOS] & xt_slow_s);

	// Stay where we are if the crystal is wanted but dead
	always_comb begin
		if (rc_want) begin
			mode_nxt = 1'b1;
		end else if (xt_run_s) begin
			mode_nxt = 1'b0;
		end else begin
			mode_nxt = mode_r;
		end
	end

	// Interrupt request from flags and enables
	always_comb begin
		irq_nxt = (of_r & ctrl_r[OSS_C_OSC_FAIL_IRQ_ENABLE])
			| (acf_r & ctrl_r[OSS_C_AUTOCAL_FAIL_IRQ_ENABLE]);
	end

	// Register all control state
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			ctrl_r <= OSS_CTRL_RST;
			key_r <= OSS_KEY_CLEARED;
			trim_r <= OSS_TRIM_RST;
			lock_r <= OSS_LOCK_RST;
			mode_r <= OSS_MODE_RST;
			of_r <= OSS_OF_RST;
			acf_r <= OSS_ACF_RST;
			level_r <= OSS_LEVEL_RST;
			autocal_mode_field_go_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			key_r <= key_nxt;
			trim_r <= trim_nxt;
			lock_r <= lock_nxt;
			mode_r <= mode_nxt;
			of_r <= of_nxt;
			acf_r <= acf_nxt;
			level_r <= level_nxt;
			autocal_mode_field_go_r <= autocal_mode_field_go_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------
	logic ready_r;
	logic ready_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic slverr_r;
	logic slverr_nxt;
	logic [7:0] stat_view;

	// Indicator is only meaningful while the clocks run
	always_comb begin
		stat_view = 8'h00;
		stat_view[OSS_S_TRIM_HI:OSS_S_TRIM_LO] = trim_r;
		stat_view[OSS_S_LOCK] = lock_r;
		stat_view[OSS_S_MODE] = mode_r;
		stat_view[OSS_S_OF] = of_r;
		stat_view[OSS_S_ACF] = acf_r;
	end

	// One wait state so that every bus output is a flop
	always_comb begin
		ready_nxt = access & ~ready_r;
		rdata_nxt = 32'h0000_0000;
		slverr_nxt = 1'b0;
		if (access && !ready_r) begin
			slverr_nxt = ~mapped;
			if (!PWRITE_I) begin
				unique case (1'b1)
					hit_ctrl: rdata_nxt = {24'h00_0000, ctrl_r};
					hit_stat: rdata_nxt = {24'h00_0000, stat_view};
					hit_key: rdata_nxt = {24'h00_0000, key_r};
					hit_out: rdata_nxt = {31'h0000_0000, level_r};
					default: rdata_nxt = 32'h0000_0000;
				endcase
			end
		end
	end

	// Answer flops
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			ready_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
		end else begin
			ready_r <= ready_nxt;
			rdata_r <= rdata_nxt;
			slverr_r <= slverr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PRDATA_O = rdata_r;
	assign PREADY_O = ready_r;
	assign PSLVERR_O = slverr_r;
	assign ACTIVE_SOURCE_RC_O = mode_r;
	assign CRYSTAL_SLOW_TRIM_O = trim_r;
	assign AUTOCAL_START_O = autocal_mode_field_go_r;
	assign AUTOCAL_MODE_O = ctrl_r[OSS_C_AUTOCAL_MODE_FIELD_HI:OSS_C_AUTOCAL_MODE_FIELD_LO];
	assign SECOND_OUTPUT_PIN_O = level_r;
	assign IRQ_O = irq_r;

endmodule : oss_ctrl

// file: testbench/oss_xtal_model.sv
`timescale 1ns/1ns
// ------------------------------
// Crystal beside the block
// ------------------------------
module oss_xtal_model #(
	parameter int unsigned STARTUP = 12
) (
	input wire logic clk_i,
	input wire logic power_i,
	input wire logic slow_i,
	input wire logic dead_i,
	output logic running_o,
	output logic slow_o,
	output logic no_start_o
);
	logic [7:0] cnt_r = 8'h00;
	// Start-up count; a dead crystal never gets going
	always_ff @(posedge clk_i) begin
		if (!power_i || dead_i) begin
			cnt_r <= 8'h00;
		end else if (cnt_r < 8'(STARTUP)) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	// Below 8 kHz it is not counted as running
	assign running_o = cnt_r == 8'(STARTUP) && !slow_i;
	assign slow_o = power_i && slow_i;
	assign no_start_o = power_i && dead_i;
endmodule : oss_xtal_model

// file: testbench/oss_props.sv
`timescale 1ns/1ns
// ------------------------------
// Port checker
// ------------------------------
module oss_props
	import oss_pkg::*;
#(
	parameter int unsigned ADDR_W = 10
) (
	input wire logic MCLK_I,
	input wire logic RESET_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic XT_RUNNING_I,
	input wire logic ACTIVE_SOURCE_RC_O,
	input wire logic [1:0] CRYSTAL_SLOW_TRIM_O,
	input wire logic AUTOCAL_START_O,
	input wire logic [1:0] AUTOCAL_MODE_O,
	input wire logic SECOND_OUTPUT_PIN_O,
	input wire logic IRQ_O
);
	logic wr, to_ctrl, to_stat, kwr, lock_r, lock_nxt;
	logic [7:0] key_r, key_nxt;
	logic [1:0] ie_r, ie_nxt;
	// Committed writes; refused ones leave the key alone
	assign wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;
	assign to_ctrl = wr && PADDR_I == ADDR_W'({OSS_IDX_CTRL, 2'b00});
	assign to_stat = wr && PADDR_I == ADDR_W'({OSS_IDX_STAT, 2'b00});
	assign kwr = to_ctrl && key_r == OSS_KEY_OSC;
	// Shadow of key, enables and lock
	always_comb begin
		key_nxt = PADDR_I == ADDR_W'({OSS_IDX_KEY, 2'b00}) ? PWDATA_I[7:0] : OSS_KEY_CLEARED;
		key_nxt = wr ? key_nxt : key_r;
		ie_nxt = kwr ? PWDATA_I[1:0] : ie_r;
		lock_nxt = to_stat ? PWDATA_I[OSS_S_LOCK] : lock_r;
	end
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			key_r <= OSS_KEY_CLEARED;
			ie_r <= 2'h0;
			lock_r <= OSS_LOCK_RST;
		end else begin
			key_r <= key_nxt;
			ie_r <= ie_nxt;
			lock_r <= lock_nxt;
		end
	end
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);
	sequence s_kwr; kwr; endsequence
	sequence s_ukwr; to_ctrl && key_r != OSS_KEY_OSC; endsequence
	property p_key; s_kwr |=> AUTOCAL_MODE_O == $past(PWDATA_I[6:5]); endproperty
	a_key: assert property (p_key) else $error("keyed write lost");
	property p_nokey; s_ukwr |=> $stable(AUTOCAL_MODE_O) && !AUTOCAL_START_O; endproperty
	a_nokey: assert property (p_nokey) else $error("unkeyed write took");
	property p_cal; s_kwr ##0 PWDATA_I[6:5] != 2'h0 |-> ##[1:2] AUTOCAL_START_O; endproperty
	a_cal: assert property (p_cal) else $error("no cal start");
	property p_rc; s_kwr ##0 PWDATA_I[7] |-> ##[1:3] ACTIVE_SOURCE_RC_O; endproperty
	a_rc: assert property (p_rc) else $error("rc not selected");
	property p_xt; $fell(ACTIVE_SOURCE_RC_O) |-> $past(XT_RUNNING_I, 3); endproperty
	a_xt: assert property (p_xt) else $error("crystal not running");
	property p_irq; IRQ_O |-> $past(ie_r) != 2'h0; endproperty
	a_irq: assert property (p_irq) else $error("irq not enabled");
	property p_trim; to_stat |=> CRYSTAL_SLOW_TRIM_O == $past(PWDATA_I[7:6]); endproperty
	a_trim: assert property (p_trim) else $error("trim wrong");
	property p_lock; $rose(SECOND_OUTPUT_PIN_O) |-> !$past(lock_r); endproperty
	a_lock: assert property (p_lock) else $error("locked output set");
endmodule : oss_props
bind oss_ctrl oss_props #(.ADDR_W(ADDR_W)) u_props (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.XT_RUNNING_I(XT_RUNNING_I), .ACTIVE_SOURCE_RC_O(ACTIVE_SOURCE_RC_O),
	.CRYSTAL_SLOW_TRIM_O(CRYSTAL_SLOW_TRIM_O), .AUTOCAL_START_O(AUTOCAL_START_O),
	.AUTOCAL_MODE_O(AUTOCAL_MODE_O), .SECOND_OUTPUT_PIN_O(SECOND_OUTPUT_PIN_O), .IRQ_O(IRQ_O));

// file: testbench/oscillator_select_status_tb.sv
`timescale 1ns/1ns
// ------------------------------
// Bench
// ------------------------------
module oscillator_select_status_tb;
	import oss_pkg::*;
	typedef struct packed {
		logic wr;
		logic [7:0] idx;
		logic [7:0] dat;
		logic err;
		logic [7:0] exp;
	} oss_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic batt = 1'b0;
	logic rcf = 1'b0;
	logic xpow = 1'b0;
	logic xslow = 1'b0;
	logic xdead = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, xrun, xslw, xns, act, st, pin, irq, er;
	logic [1:0] trim, mode;
	logic [7:0] rd;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	int n_start = 0;
	// Accesses and their answers: write, index, data, error, read value
	oss_row_t rows [13] = '{'{0, 8'h1d, 8'h00, 0, 8'h22}, '{0, 8'h1c, 8'h00, 0, 8'h00},
		'{1, 8'h1c, 8'h80, 0, 8'h00}, '{0, 8'h1c, 8'h00, 0, 8'h00}, '{1, 8'h1f, 8'ha1, 0, 8'h00},
		'{1, 8'h1c, 8'h9f, 0, 8'h00}, '{1, 8'h1c, 8'h00, 0, 8'h00}, '{0, 8'h1c, 8'h00, 0, 8'h9b},
		'{0, 8'h00, 8'h00, 1, 8'h00}, '{1, 8'h1d, 8'hc0, 0, 8'h00}, '{0, 8'h1d, 8'h00, 0, 8'hd0},
		'{1, 8'h3f, 8'h01, 0, 8'h00}, '{0, 8'h3f, 8'h00, 0, 8'h01}};
	oss_ctrl dut_u (.MCLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .XT_RUNNING_I(xrun), .ON_BATTERY_I(batt), .XT_SLOW_I(xslw),
		.RC_RANGE_FAIL_I(rcf), .XT_NO_START_I(xns), .ACTIVE_SOURCE_RC_O(act),
		.CRYSTAL_SLOW_TRIM_O(trim), .AUTOCAL_START_O(st), .AUTOCAL_MODE_O(mode),
		.SECOND_OUTPUT_PIN_O(pin), .IRQ_O(irq));
	oss_xtal_model xtal_u (.clk_i(clk), .power_i(xpow), .slow_i(xslow), .dead_i(xdead),
		.running_o(xrun), .slow_o(xslw), .no_start_o(xns));
	always #2 clk = ~clk;
	// Hang guard; also counts calibration start pulses
	always @(posedge clk) begin
		cyc++;
		if (st === 1'b1) begin
			n_start++;
		end
		if (cyc == 4000) begin
			n_errors++;
			stop_test();
		end
	end
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// One transfer; request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic kw(input logic [7:0] d);
		apb(1, 8'h1f, OSS_KEY_OSC);
		apb(1, 8'h1c, d);
		repeat (10) @(posedge clk);
	endtask : kw
	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].idx, rows[i].dat);
			chk({er, rows[i].wr ? 8'h00 : rd}, rows[i][8:0]);
		end
		chk({trim, pin}, 9'h007);
		$display("table done");
		// Locked output refuses a one
		apb(1, 8'h1d, 8'h20);
		apb(1, 8'h3f, 8'h00);
		apb(1, 8'h3f, 8'h01);
		apb(0, 8'h3f, 8'h00);
		chk({rd, pin}, 9'h000);
		$display("lock done");
		for (int m = 1; m < 4; m++) begin
			kw({1'b1, 2'(m), 5'h00});
			chk({n_start[6:0], mode}, {7'(m), 2'(m)});
		end
		apb(1, 8'h1c, 8'h60);
		repeat (10) @(posedge clk);
		chk(9'(n_start), 9'h003);
		$display("calibration done");
		// Crystal asked for before it runs
		kw(8'h00);
		chk(9'(act), 9'h001);
		xpow <= 1'b1;
		repeat (40) @(posedge clk);
		chk(9'(act), 9'h000);
		batt <= 1'b1;
		kw(8'h10);
		chk(9'(act), 9'h001);
		batt <= 1'b0;
		kw(8'h00);
		$display("source done");
		kw(8'h0a);
		xslow <= 1'b1;
		repeat (10) @(posedge clk);
		chk({act, irq}, 9'h003);
		xslow <= 1'b0;
		kw(8'h0a);
		chk({act, irq}, 9'h001);
		apb(1, 8'h1d, 8'h00);
		rcf <= 1'b1;
		kw(8'h01);
		rcf <= 1'b0;
		apb(0, 8'h1d, 8'h00);
		chk({rd, irq}, 9'h003);
		// Calibration flag clears by a zero write, then a dead crystal sets it
		apb(1, 8'h1d, 8'h00);
		apb(0, 8'h1d, 8'h00);
		chk({rd, irq}, 9'h000);
		xdead <= 1'b1;
		repeat (10) @(posedge clk);
		apb(0, 8'h1d, 8'h00);
		chk({rd, irq}, 9'h003);
		xdead <= 1'b0;
		$display("flags done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(0, 8'h1d, 8'h00);
		chk({rd, irq}, 9'h044);
		$display("reset done");
		stop_test();
	end
endmodule : oscillator_select_status_tb
